/* gps_host_model.sv */
// Host side model: reads sentence bytes off the serial line and sends command bytes
`timescale 1ns/1ps
module gps_host_model (
  // Clock and bit period in clocks
  input wire logic pclk,
  input wire logic [15:0] baud,
  // Serial lines
  input wire logic serial_tx_out,
  output logic serial_rx_in,
  // Byte taken from the device
  output logic [7:0] got_byte,
  output logic got_stb
);
  logic [7:0] sh;
  initial
  begin
    serial_rx_in = 1'b1;
    got_stb = 1'b0;
    got_byte = 8'h00;
  end
  // Samples each bit mid-period, LSB first; a low stop bit drops the byte
  always
  begin
    @(negedge serial_tx_out);
    repeat (baud / 2) @(posedge pclk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (baud) @(posedge pclk);
      sh[i] = serial_tx_out;
    end
    repeat (baud) @(posedge pclk);
    got_byte <= sh;
    got_stb <= serial_tx_out;
    @(posedge pclk);
    got_stb <= 1'b0;
  end
  // Command byte, 8N1, line left high after the stop bit
  task automatic send(input logic [7:0] v);
    logic [9:0] f;
    f = {1'b1, v, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge pclk);
      serial_rx_in <= f[i];
      repeat (baud - 1) @(posedge pclk);
    end
  endtask
endmodule

/* gps_pkg.sv */
// Types shared by the status pin block
package gps_pkg;
  typedef enum logic [1:0] {start_hot, start_warm, start_cold} gps_start_e;
  typedef enum logic {mode_active, mode_low_power} gps_mode_e;
  typedef enum logic [1:0] {cp_idle, cp_held, cp_long} gps_clr_e;
  typedef enum logic [1:0] {rx_idle, rx_start, rx_data, rx_stop} gps_rx_e;
endpackage

/* gps_regs.svh */
// Register map, field positions, reset values and timing figures of the status pin block
`ifndef GPS_REGS_SVH
`define GPS_REGS_SVH
`define GPS_OFF_CTRL 12'h000
`define GPS_OFF_PCFG 12'h004
`define GPS_OFF_STAT 12'h008
`define GPS_OFF_IST 12'h00c
`define GPS_OFF_IMSK 12'h010
`define GPS_OFF_RXD 12'h014
`define GPS_OFF_BAUD 12'h018
`define GPS_CTRL_LP 0
`define GPS_CTRL_PPSEN 1
`define GPS_CTRL_RST 2'h2
`define GPS_PCFG_RST 16'h0064
`define GPS_BAUD_RST 16'h208d
`define GPS_IRQ_SHORT 0
`define GPS_IRQ_LONG 1
`define GPS_IRQ_RX 2
`define GPS_IRQ_FIX 3
`define GPS_IRQ_W 4
`define GPS_CLK_PERIOD_NS 25
`define GPS_MS_NS 1000000
`define GPS_SHORT_MS 1500
`define GPS_LONG_MS 3000
`define GPS_HALF_MS 500
`define GPS_EPH_MAX_H 4
`define GPS_SEC_PER_H 3600
`endif

/* gps_status_pins.sv */
// Status pins, clear-position input, start selection and NMEA serial port of the receiver
// Function
// - Timing pulse only while fixing, else low
// - Timing pulse rising edge on GPS second
// - Pulse setting defaults at reset, writable later
// - Fix indicator 1Hz square searching, low fixing
// - Almanac output high only when data valid
// - Short clear press deletes stored position
// - Short clear ignored while already fixing
// - Long clear press erases flash, cold restart
// - After clear, fix before saving to flash
// - Active mode and command-entered low-power mode
// - Power-down stops everything but the clock
// - Hot, warm or cold start on entry
// - Power-up gives active mode, default sentences
// - Sentences leave without any host setup
// - Host serial commands received and handled
// - Modified settings revert at next power loss
`timescale 1ns/1ps
`include "gps_regs.svh"
module gps_status_pins #(
  parameter int unsigned MS_CYCLES = `GPS_MS_NS / `GPS_CLK_PERIOD_NS
) (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Navigation engine status
  input wire logic fix_valid,
  input wire logic gps_sec_tick,
  input wire logic alm_valid,
  input wire logic eph_valid,
  input wire logic [15:0] eph_age_s,
  input wire logic pos_known,
  input wire logic rtc_valid,
  // Sentence byte stream
  input wire logic [7:0] tx_byte,
  input wire logic tx_valid,
  output logic tx_ready,
  // Device pins
  input wire logic clear_position_n,
  input wire logic serial_rx_in,
  output logic timing_pulse_out,
  output logic fix_indicator_out,
  output logic almanac_valid_out,
  output logic serial_tx_out,
  // Engine control
  output logic receiver_enable,
  output logic engine_start,
  output logic [1:0] start_kind,
  output logic delete_position,
  output logic erase_flash,
  output logic flash_save_ok,
  output logic irq
);
  localparam logic [15:0] MS_LAST = 16'(MS_CYCLES - 1);
  localparam logic [11:0] SHORT_MS = 12'(`GPS_SHORT_MS);
  localparam logic [11:0] LONG_MS = 12'(`GPS_LONG_MS);
  localparam logic [11:0] HALF_LAST = 12'(`GPS_HALF_MS - 1);
  localparam logic [15:0] EPH_MAX_S = 16'(`GPS_EPH_MAX_H * `GPS_SEC_PER_H);

  logic [1:0] ctrl_q;
  logic [15:0] pcfg_q;
  logic [15:0] baud_q;
  logic [`GPS_IRQ_W-1:0] ist_q;
  logic [`GPS_IRQ_W-1:0] imsk_q;
  logic [7:0] rxd_q;
  logic [2:0] clr_s_q;
  logic [2:0] rx_s_q;
  logic clr_f_q;
  logic rx_f_q;
  logic [15:0] ms_cnt_q;
  logic ms_tick;
  logic pps_q;
  logic [15:0] pps_ms_q;
  logic fi_q;
  logic [11:0] half_q;
  logic alm_q;
  gps_pkg::gps_mode_e mode_q;
  gps_pkg::gps_clr_e clr_st_q;
  logic [11:0] press_q;
  logic del_q;
  logic erase_q;
  logic boot_q;
  logic start_q;
  gps_pkg::gps_start_e kind_q;
  logic save_ok_q;
  logic fix_d1_q;
  logic tx_busy_q;
  logic [9:0] tx_sh_q;
  logic [3:0] tx_bits_q;
  logic [15:0] tx_bc_q;
  gps_pkg::gps_rx_e rx_st_q;
  logic [15:0] rx_bc_q;
  logic [2:0] rx_bits_q;
  logic [7:0] rx_sh_q;
  logic rx_done;
  logic [31:0] rdata_q;
  logic err_q;
  logic wr;
  logic [`GPS_IRQ_W-1:0] ev;
  logic active;
  logic lp_req;
  logic [31:0] rsel;
  logic hit;

  assign active = (mode_q == gps_pkg::mode_active);
  assign lp_req = ctrl_q[`GPS_CTRL_LP];
  assign wr = psel && penable && pwrite;
  assign pready = 1'b1;
  assign prdata = rdata_q;
  assign pslverr = err_q;

  // Outside inputs pass three flops; a level counts once stages two and three agree
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      clr_s_q <= 3'h7;
      rx_s_q <= 3'h7;
      clr_f_q <= 1'b1;
      rx_f_q <= 1'b1;
    end
    else
    begin
      clr_s_q <= {clr_s_q[1:0], clear_position_n};
      rx_s_q <= {rx_s_q[1:0], serial_rx_in};
      if (clr_s_q[1] == clr_s_q[2])
        clr_f_q <= clr_s_q[2];
      if (rx_s_q[1] == rx_s_q[2])
        rx_f_q <= rx_s_q[2];
    end
  end

  // Millisecond enable
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ms_cnt_q <= 16'h0000;
    else if (ms_cnt_q == MS_LAST)
      ms_cnt_q <= 16'h0000;
    else
      ms_cnt_q <= ms_cnt_q + 16'h0001;
  end
  assign ms_tick = (ms_cnt_q == MS_LAST);

  // Power loss is the reset: settings fall back to stored defaults
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= `GPS_CTRL_RST;
      pcfg_q <= `GPS_PCFG_RST;
      baud_q <= `GPS_BAUD_RST;
      imsk_q <= '0;
    end
    else if (wr)
    begin
      case (paddr)
        `GPS_OFF_CTRL: ctrl_q <= pwdata[1:0];
        `GPS_OFF_PCFG: pcfg_q <= pwdata[15:0];
        `GPS_OFF_BAUD: baud_q <= pwdata[15:0];
        `GPS_OFF_IMSK: imsk_q <= pwdata[`GPS_IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // Sticky events, write one to clear; a new event wins over the clear
  assign ev[`GPS_IRQ_SHORT] = del_q;
  assign ev[`GPS_IRQ_LONG] = erase_q;
  assign ev[`GPS_IRQ_RX] = rx_done;
  assign ev[`GPS_IRQ_FIX] = fix_valid && !fix_d1_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ist_q <= '0;
    else if (wr && paddr == `GPS_OFF_IST)
      ist_q <= (ist_q & ~pwdata[`GPS_IRQ_W-1:0]) | ev;
    else
      ist_q <= ist_q | ev;
  end
  assign irq = |(ist_q & imsk_q);

  // Read data and error captured in the setup phase, answered in the first access cycle
  always_comb
  begin
    hit = 1'b1;
    rsel = 32'h0000_0000;
    case (paddr)
      `GPS_OFF_CTRL: rsel = {30'h0, ctrl_q};
      `GPS_OFF_PCFG: rsel = {16'h0, pcfg_q};
      `GPS_OFF_STAT: rsel = {25'h0, clr_f_q, save_ok_q, kind_q, alm_q, fix_valid, mode_q};
      `GPS_OFF_IST: rsel = {28'h0, ist_q};
      `GPS_OFF_IMSK: rsel = {28'h0, imsk_q};
      `GPS_OFF_RXD: rsel = {24'h0, rxd_q};
      `GPS_OFF_BAUD: rsel = {16'h0, baud_q};
      default: hit = 1'b0;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rdata_q <= 32'h0000_0000;
      err_q <= 1'b0;
    end
    else if (psel && !penable)
    begin
      rdata_q <= pwrite ? 32'h0000_0000 : rsel;
      err_q <= !hit;
    end
  end

  // Low-power entered and left by command; power-up always active
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mode_q <= gps_pkg::mode_active;
    else
      mode_q <= lp_req ? gps_pkg::mode_low_power : gps_pkg::mode_active;
  end
  // Held off while power is away and until the first edge after it returns
  assign receiver_enable = active && boot_q;

  // Timing pulse on the GPS-aligned second tick, width in ms
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pps_q <= 1'b0;
      pps_ms_q <= 16'h0000;
    end
    else if (!(fix_valid && active && ctrl_q[`GPS_CTRL_PPSEN]))
    begin
      pps_q <= 1'b0;
      pps_ms_q <= 16'h0000;
    end
    else if (gps_sec_tick)
    begin
      pps_q <= 1'b1;
      pps_ms_q <= 16'h0000;
    end
    else if (pps_q && ms_tick)
    begin
      pps_ms_q <= pps_ms_q + 16'h0001;
      if (pps_ms_q + 16'h0001 >= pcfg_q)
        pps_q <= 1'b0;
    end
  end
  assign timing_pulse_out = pps_q;

  // Fix indicator: square wave while searching, low when fixing
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fi_q <= 1'b0;
      half_q <= 12'h000;
    end
    else if (!active || fix_valid)
    begin
      fi_q <= 1'b0;
      half_q <= 12'h000;
    end
    else if (ms_tick)
    begin
      if (half_q == HALF_LAST)
      begin
        half_q <= 12'h000;
        fi_q <= !fi_q;
      end
      else
        half_q <= half_q + 12'h001;
    end
  end
  assign fix_indicator_out = fi_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      alm_q <= 1'b0;
    else
      alm_q <= active && alm_valid;
  end
  assign almanac_valid_out = alm_q;

  // Clear-position press timing
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      clr_st_q <= gps_pkg::cp_idle;
      press_q <= 12'h000;
      del_q <= 1'b0;
      erase_q <= 1'b0;
    end
    else
    begin
      del_q <= 1'b0;
      erase_q <= 1'b0;
      case (clr_st_q)
        gps_pkg::cp_idle:
          if (!clr_f_q)
          begin
            clr_st_q <= gps_pkg::cp_held;
            press_q <= 12'h000;
          end
        gps_pkg::cp_held:
          if (clr_f_q)
          begin
            clr_st_q <= gps_pkg::cp_idle;
            del_q <= (press_q < SHORT_MS) && !fix_valid;
          end
          else if (press_q > LONG_MS)
          begin
            erase_q <= 1'b1;
            clr_st_q <= gps_pkg::cp_long;
          end
          else if (ms_tick)
            press_q <= press_q + 12'h001;
        gps_pkg::cp_long:
          if (clr_f_q)
            clr_st_q <= gps_pkg::cp_idle;
        default: clr_st_q <= gps_pkg::cp_idle;
      endcase
    end
  end
  assign delete_position = del_q;
  assign erase_flash = erase_q;

  // Flash save allowed only after a fix that follows any clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      save_ok_q <= 1'b0;
      fix_d1_q <= 1'b0;
    end
    else
    begin
      fix_d1_q <= fix_valid;
      if (del_q || erase_q)
        save_ok_q <= 1'b0;
      else if (fix_valid)
        save_ok_q <= 1'b1;
    end
  end
  assign flash_save_ok = save_ok_q;

  // Start kind on every entry to active mode, cold after flash erase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      boot_q <= 1'b0;
      start_q <= 1'b0;
      kind_q <= gps_pkg::start_cold;
    end
    else
    begin
      boot_q <= 1'b1;
      start_q <= erase_q || (!lp_req && (!boot_q || !active));
      if (erase_q)
        kind_q <= gps_pkg::start_cold;
      else if (!lp_req && (!boot_q || !active))
      begin
        if (alm_valid && pos_known && rtc_valid && eph_valid && eph_age_s < EPH_MAX_S)
          kind_q <= gps_pkg::start_hot;
        else if (alm_valid && pos_known && rtc_valid)
          kind_q <= gps_pkg::start_warm;
        else
          kind_q <= gps_pkg::start_cold;
      end
    end
  end
  assign engine_start = start_q;
  assign start_kind = kind_q;

  // Sentence transmitter, free running from power-up
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_busy_q <= 1'b0;
      tx_sh_q <= 10'h3ff;
      tx_bits_q <= 4'h0;
      tx_bc_q <= 16'h0000;
    end
    else if (!tx_busy_q)
    begin
      if (tx_valid)
      begin
        tx_busy_q <= 1'b1;
        tx_sh_q <= {1'b1, tx_byte, 1'b0};
        tx_bits_q <= 4'h0;
        tx_bc_q <= 16'h0000;
      end
    end
    else if (tx_bc_q + 16'h0001 >= baud_q)
    begin
      tx_bc_q <= 16'h0000;
      tx_sh_q <= {1'b1, tx_sh_q[9:1]};
      if (tx_bits_q == 4'h9)
        tx_busy_q <= 1'b0;
      else
        tx_bits_q <= tx_bits_q + 4'h1;
    end
    else
      tx_bc_q <= tx_bc_q + 16'h0001;
  end
  assign tx_ready = !tx_busy_q;
  assign serial_tx_out = tx_sh_q[0];

  // Command receiver, 8N1, sampled mid-bit
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_st_q <= gps_pkg::rx_idle;
      rx_bc_q <= 16'h0000;
      rx_bits_q <= 3'h0;
      rx_sh_q <= 8'h00;
      rxd_q <= 8'h00;
    end
    else
    begin
      rx_bc_q <= rx_bc_q + 16'h0001;
      case (rx_st_q)
        gps_pkg::rx_idle:
        begin
          rx_bc_q <= 16'h0000;
          if (!rx_f_q)
            rx_st_q <= gps_pkg::rx_start;
        end
        gps_pkg::rx_start:
          if (rx_bc_q >= {1'b0, baud_q[15:1]})
          begin
            rx_bc_q <= 16'h0000;
            rx_bits_q <= 3'h0;
            rx_st_q <= rx_f_q ? gps_pkg::rx_idle : gps_pkg::rx_data;
          end
        gps_pkg::rx_data:
          if (rx_bc_q + 16'h0001 >= baud_q)
          begin
            rx_bc_q <= 16'h0000;
            rx_sh_q <= {rx_f_q, rx_sh_q[7:1]};
            rx_bits_q <= rx_bits_q + 3'h1;
            if (rx_bits_q == 3'h7)
              rx_st_q <= gps_pkg::rx_stop;
          end
        gps_pkg::rx_stop:
          if (rx_bc_q + 16'h0001 >= baud_q)
          begin
            rx_st_q <= gps_pkg::rx_idle;
            if (rx_f_q)
              rxd_q <= rx_sh_q;
          end
        default: rx_st_q <= gps_pkg::rx_idle;
      endcase
    end
  end
  assign rx_done = (rx_st_q == gps_pkg::rx_stop) && (rx_bc_q + 16'h0001 >= baud_q) && rx_f_q;

  chk_pps_low_nofix: assert property (@(posedge pclk) disable iff (!presetn)
    !fix_valid |=> !timing_pulse_out) else $error("timing pulse high without fix");
  chk_pps_rise_tick: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(timing_pulse_out) |-> $past(gps_sec_tick)) else $error("timing pulse rise not on second tick");
  chk_pps_width: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(timing_pulse_out) && pcfg_q > 16'h0001 |=> timing_pulse_out [*8]) else $error("timing pulse too short");
  chk_fix_ind_low: assert property (@(posedge pclk) disable iff (!presetn)
    fix_valid && active |=> !fix_indicator_out) else $error("fix indicator high while fixing");
  chk_alm_out: assert property (@(posedge pclk) disable iff (!presetn)
    almanac_valid_out |-> $past(alm_valid) && $past(active)) else $error("almanac output without valid data");
  chk_short_ignored: assert property (@(posedge pclk) disable iff (!presetn)
    delete_position |-> !$past(fix_valid) && $past(press_q) < SHORT_MS) else $error("bad position delete");
  chk_long_cold: assert property (@(posedge pclk) disable iff (!presetn)
    erase_flash |=> engine_start && start_kind == gps_pkg::start_cold) else $error("no cold start after erase");
  chk_save_block: assert property (@(posedge pclk) disable iff (!presetn)
    delete_position |=> !flash_save_ok) else $error("flash save allowed after clear");
  chk_lp_stop: assert property (@(posedge pclk) disable iff (!presetn)
    $past(lp_req) |-> !receiver_enable) else $error("receiver running in low power");
  chk_hot_cond: assert property (@(posedge pclk) disable iff (!presetn)
    engine_start && start_kind == gps_pkg::start_hot |-> $past(eph_age_s) < EPH_MAX_S && $past(eph_valid))
    else $error("hot start without fresh ephemeris");
endmodule

/* test_gps_status_pins.sv */
// Self-checking bench for the status pin block with a host serial model
`timescale 1ns/1ps
`include "gps_regs.svh"
module test_gps_status_pins;
  localparam int MS = 10;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, fix_valid, gps_sec_tick, alm_valid, eph_valid;
  logic pos_known, rtc_valid, tx_valid, tx_ready, clear_position_n, serial_rx_in, timing_pulse_out;
  logic fix_indicator_out, almanac_valid_out, serial_tx_out, receiver_enable, engine_start, delete_position;
  logic erase_flash, flash_save_ok, irq, got_stb, p;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] eph_age_s, baud;
  logic [7:0] tx_byte, got_byte, b;
  logic [1:0] start_kind;
  logic [32:0] rd_q[$];
  logic [7:0] tx_q[$];
  logic [1:0] st_q[$];
  int err_count, num_checks, n_del, n_er, n;

  gps_status_pins #(.MS_CYCLES(MS)) gps_status_pins_i (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .fix_valid, .gps_sec_tick, .alm_valid, .eph_valid, .eph_age_s,
    .pos_known, .rtc_valid, .tx_byte, .tx_valid, .tx_ready, .clear_position_n, .serial_rx_in,
    .timing_pulse_out, .fix_indicator_out, .almanac_valid_out, .serial_tx_out, .receiver_enable,
    .engine_start, .start_kind, .delete_position, .erase_flash, .flash_save_ok, .irq);
  gps_host_model gps_host_model_i (.pclk, .baud, .serial_tx_out, .serial_rx_in, .got_byte, .got_stb);

  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic check(input logic [32:0] seen, input logic [32:0] exp, input string what);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w)
      rd_q.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, {1'b0, e});
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
    #1;
  endtask

  task automatic send_tx(input logic [7:0] v);
    @(posedge pclk);
    tx_byte <= v;
    tx_valid <= 1'b1;
    tx_q.push_back(v);
    do @(posedge pclk); while (tx_ready !== 1'b1);
    tx_valid <= 1'b0;
  endtask

  task automatic tick();
    @(posedge pclk);
    gps_sec_tick <= 1'b1;
    @(posedge pclk);
    gps_sec_tick <= 1'b0;
    #1;
  endtask

  task automatic press(input int ms);
    @(posedge pclk);
    clear_position_n <= 1'b0;
    cyc(ms * MS);
    @(posedge pclk);
    clear_position_n <= 1'b1;
    cyc(20);
  endtask

  // Result watcher: takes the oldest note for each read, serial byte and engine start that appears; counts deletes and erases
  always @(posedge pclk)
  begin
    if (psel && penable && pready === 1'b1 && !pwrite)
      check({pslverr, prdata}, rd_q.pop_front(), "apb read");
    if (got_stb === 1'b1)
      check(got_byte, tx_q.pop_front(), "serial byte");
    if (engine_start === 1'b1)
      check(start_kind, st_q.size() > 0 ? st_q.pop_front() : 2'h3, "start kind");
    if (delete_position === 1'b1)
      n_del++;
    if (erase_flash === 1'b1)
      n_er++;
  end

  initial
  begin
    #(25 * 95000);
    err_count++;
    $display("MISMATCH watchdog expected done seen timeout");
    tally_and_finish();
  end

  initial
  begin
    {psel, penable, pwrite, gps_sec_tick, tx_valid, fix_valid} = '0;
    {alm_valid, eph_valid, pos_known, rtc_valid, clear_position_n} = '1;
    paddr = 12'h000;
    pwdata = 32'h0;
    tx_byte = 8'h00;
    eph_age_s = 16'h0010;
    baud = 16'h0010;
    presetn = 1'b0;
    void'($urandom(32'hfe64));
    st_q.push_back(2'h0);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(`GPS_OFF_CTRL, 32'h2);
    check(receiver_enable, 1'b1, "receiver enable");
    rd(`GPS_OFF_PCFG, 32'h64);
    rd(`GPS_OFF_BAUD, 32'h208d);
    rd(`GPS_OFF_IST, 32'h0);
    rd(`GPS_OFF_STAT, 32'h44);
    apb(1'b0, 12'h01c, 32'h0, {1'b1, 32'h0});
    wr(`GPS_OFF_BAUD, 32'h10);
    repeat (2) send_tx(8'($urandom));
    cyc(400);
    wr(`GPS_OFF_IMSK, 32'h0);
    b = 8'($urandom);
    gps_host_model_i.send(b);
    cyc(20);
    rd(`GPS_OFF_RXD, {24'h0, b});
    rd(`GPS_OFF_IST, 32'h4);
    check(irq, 1'b0, "irq masked");
    wr(`GPS_OFF_IMSK, 32'h4);
    cyc(2);
    check(irq, 1'b1, "irq raised");
    wr(`GPS_OFF_IST, 32'h4);
    cyc(2);
    check(irq, 1'b0, "irq cleared");
    // Ephemeris age just under and then at the limit, then a bad clock
    for (int k = 0; k < 3; k++)
    begin
      @(posedge pclk);
      eph_age_s <= (k == 0) ? 16'h383f : 16'h3840;
      rtc_valid <= (k != 2);
      wr(`GPS_OFF_CTRL, 32'h3);
      cyc(5);
      check(receiver_enable, 1'b0, "low power");
      st_q.push_back(2'(k));
      wr(`GPS_OFF_CTRL, 32'h2);
      cyc(5);
      check(receiver_enable, 1'b1, "active");
    end
    rtc_valid <= 1'b1;
    for (int v = 0; v < 2; v++)
    begin
      alm_valid <= v[0];
      cyc(10);
      check(almanac_valid_out, v[0], "almanac");
    end
    n = 0;
    p = fix_indicator_out;
    repeat (12000)
    begin
      cyc(1);
      if (fix_indicator_out !== p)
        n++;
      p = fix_indicator_out;
    end
    check(n >= 2 && n <= 3, 1'b1, "fix toggles");
    fix_valid <= 1'b1;
    cyc(10);
    check(fix_indicator_out, 1'b0, "fix steady");
    wr(`GPS_OFF_PCFG, 32'h3);
    tick();
    check(timing_pulse_out, 1'b1, "pulse rise");
    cyc(15);
    check(timing_pulse_out, 1'b1, "pulse held");
    cyc(20);
    check(timing_pulse_out, 1'b0, "pulse end");
    wr(`GPS_OFF_CTRL, 32'h0);
    tick();
    check(timing_pulse_out, 1'b0, "pulse off");
    wr(`GPS_OFF_CTRL, 32'h2);
    fix_valid <= 1'b0;
    tick();
    check(timing_pulse_out, 1'b0, "no fix pulse");
    fix_valid <= 1'b1;
    press(100);
    check(n_del, 0, "clear while fixing");
    fix_valid <= 1'b0;
    press(100);
    check(n_del, 1, "clear short");
    check(flash_save_ok, 1'b0, "save held");
    fix_valid <= 1'b1;
    cyc(100);
    check(flash_save_ok, 1'b1, "save allowed");
    fix_valid <= 1'b0;
    press(2000);
    check({n_del[3:0], n_er[3:0]}, 8'h10, "clear middle");
    st_q.push_back(2'h2);
    press(3500);
    check(n_er, 1, "clear long");
    // Ephemeris age was left at the limit, so power-up gives a warm start
    st_q.push_back(2'h1);
    @(posedge pclk);
    presetn <= 1'b0;
    cyc(1);
    check({timing_pulse_out, serial_tx_out, receiver_enable}, 3'b010, "power down");
    @(posedge pclk);
    presetn <= 1'b1;
    rd(`GPS_OFF_PCFG, 32'h64);
    rd(`GPS_OFF_BAUD, 32'h208d);
    cyc(10);
    check(st_q.size() + tx_q.size() + rd_q.size(), 0, "pending notes");
    tally_and_finish();
  end
endmodule
